// file: src/nvcs_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvcs_defines.svh"
module nvcs_top import nvcs_pkg::*; #(
   parameter int CFG_WORDS = 4,
   parameter int NV_WR_CYC = `NVCS_NV_WR_CYC,
   // Arbitrary key value
   parameter logic [13:0] SEC_KEY = 14'h1a5c
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic nvm_erase_n,

   // Decoded command port of the serial management engine
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_rd,
   input wire logic [15:0] cmd_wdata,
   output logic cmd_ready,
   output logic rd_valid,
   output logic [15:0] rd_data,

   // Pins
   input wire logic wp_pin,
   input wire logic step_clock_line,
   input wire logic shared_sync_line,
   input wire logic alert_in_n,
   output logic alert_out_n,
   output logic alert_oe,

   // Sequencing engine events
   input wire logic seq_up_start,
   input wire logic seq_up_done,
   input wire logic seq_down_start,
   input wire logic seq_down_done,
   input wire logic [5:0] seq_fault_chan_evt,
   input wire logic rise_fault,
   input wire logic fall_fault,
   input wire logic over_trip,
   input wire logic under_trip,
   input wire logic supervise_trip,
   input wire logic seq_ctl_fault,
   input wire logic ext_fault,
   input wire logic all_discharged,
   input wire logic [15:0] hist_word,

   // Working configuration
   input wire logic [CFG_WORDS*16-1:0] cfg_work,
   output logic cfg_load_valid,
   output logic [CFG_WORDS*16-1:0] cfg_load_data,
   output logic clear_pulse,
   output logic nvm_busy
);
   nvcs_top_t s_r;
   nvcs_top_t s_nxt;
   nvcs_if #(.CFG_WORDS(CFG_WORDS)) nv_bus ();
   logic [2:0] pin_q;
   logic wp_s;
   logic step_s;
   logic sync_s;
   logic take;
   logic step_edge;
   logic sync_fault;
   logic seq_evt;
   logic sv_evt;
   logic fault_evt;
   logic summ_clr;
   logic [2:0] chan_code;
   logic [1:0] own_code;
   logic [1:0] group_code;
   logic [15:0] summary;
   logic store_ok;
   logic alert_rel;
   logic unused_in;
   logic rd_take;
   logic wr_take;
   logic key_match;
   logic first_fault;
   logic group_busy;
   logic [15:0] rd_word;

   // Line timing limits in clock cycles
   localparam logic [7:0] STEP_RELOAD = 8'(`NVCS_STEP_TMO_CYC);
   localparam logic [7:0] SYNC_LAST = 8'(`NVCS_SYNC_LOW_CYC - 1);
   localparam logic [7:0] SYNC_STOP = 8'(`NVCS_SYNC_LOW_CYC);

   // Pin synchronisers
   nvcs_sync #(.W(3)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({wp_pin, step_clock_line, shared_sync_line}),
      .q(pin_q)
   );

   // Nonvolatile engine
   nvcs_nvm #(.CFG_WORDS(CFG_WORDS), .WR_CYC(NV_WR_CYC)) u_nvm (
      .clk(clk),
      .rst_n(rst_n),
      .nvm_erase_n(nvm_erase_n),
      .bus(nv_bus)
   );

   assign wp_s = pin_q[2];
   assign step_s = pin_q[1];
   assign sync_s = pin_q[0];
   assign unused_in = alert_in_n;

   // Lowest faulting channel wins
   always_comb begin
      chan_code = `NVCS_CHAN_NONE;
      for (int i = 5; i >= 0; i--) begin
         if (s_r.chan_seen[i]) begin
            chan_code = 3'(i + 1);
         end
      end
   end

   always_comb begin
      unique case (s_r.own_ph)
         ph_down_done: begin
            own_code = `NVCS_PH_DOWN_DONE;
         end
         ph_up_run: begin
            own_code = `NVCS_PH_UP_RUN;
         end
         ph_up_done: begin
            own_code = `NVCS_PH_UP_DONE;
         end
         ph_down_run: begin
            own_code = `NVCS_PH_DOWN_RUN;
         end
      endcase
   end

   // Group phase: step clock activity means some device is still stepping
   assign group_busy = (s_r.step_tmo != 8'h00);

   always_comb begin
      if (group_busy && s_r.own_up) begin
         group_code = `NVCS_PH_UP_RUN;
      end else if (group_busy) begin
         group_code = `NVCS_PH_DOWN_RUN;
      end else if (s_r.own_up) begin
         group_code = `NVCS_PH_UP_DONE;
      end else begin
         group_code = `NVCS_PH_DOWN_DONE;
      end
   end

   always_comb begin
      summary = {chan_code,
                 nv_bus.copy_valid,
                 own_code,
                 group_code,
                 s_r.rise_f, s_r.fall_f,
                 s_r.over_f, s_r.under_f, s_r.sv_f,
                 s_r.dis,
                 s_r.ctl_f, s_r.oth_f};
   end

   // Read multiplexer
   always_comb begin
      unique case (cmd_code)
         `NVCS_CMD_ALERT_REL: begin
            rd_word = `NVCS_ZERO16;
         end
         `NVCS_CMD_SUMMARY: begin
            rd_word = summary;
         end
         `NVCS_CMD_LOCK: begin
            rd_word = {15'h0000, s_r.lock};
         end
         default: begin
            rd_word = `NVCS_ZERO16;
         end
      endcase
   end

   // Line activity
   assign step_edge = step_s ^ s_r.step_d;
   assign sync_fault = (s_r.sync_low == SYNC_LAST) && !sync_s;
   assign seq_evt = (|seq_fault_chan_evt) | rise_fault | fall_fault | seq_ctl_fault;
   assign sv_evt = over_trip | under_trip | supervise_trip;
   assign fault_evt = seq_evt | sv_evt | ext_fault | sync_fault;
   assign cmd_ready = !nv_bus.busy && !s_r.por_pend && !s_r.store_req && !s_r.restore_req;

   // Command decode
   assign take = cmd_valid && cmd_ready;
   assign rd_take = take && cmd_rd;
   assign wr_take = take && !cmd_rd;
   assign key_match = (cmd_wdata[`NVCS_KEY_MSB:`NVCS_KEY_LSB] == SEC_KEY);
   assign store_ok = !wp_s && !s_r.lock && s_r.key_ok;
   assign alert_rel = rd_take && (cmd_code == `NVCS_CMD_ALERT_REL);
   assign summ_clr = seq_up_start || (wr_take && (cmd_code == `NVCS_CMD_CLEAR));
   assign first_fault = (seq_evt || sv_evt) && s_r.armed && !nv_bus.copy_valid;

   always_comb begin
      s_nxt = s_r;
      s_nxt.rd_valid = 1'b0;
      s_nxt.clr_pulse = 1'b0;
      s_nxt.store_req = 1'b0;
      s_nxt.erase_req = 1'b0;
      s_nxt.restore_req = 1'b0;
      s_nxt.capture_req = 1'b0;
      s_nxt.step_d = step_s;
      s_nxt.dis = all_discharged;

      // Power-up reload without any host command
      if (s_r.por_pend) begin
         s_nxt.restore_req = 1'b1;
         s_nxt.por_pend = 1'b0;
      end

      if (step_edge) begin
         s_nxt.step_tmo = STEP_RELOAD;
      end else if (s_r.step_tmo != 8'h00) begin
         s_nxt.step_tmo = s_r.step_tmo - 8'h01;
      end

      if (sync_s) begin
         s_nxt.sync_low = 8'h00;
      end else if (s_r.sync_low != SYNC_STOP) begin
         s_nxt.sync_low = s_r.sync_low + 8'h01;
      end

      // Summary flags: clear first, so a same-cycle event still sets
      if (summ_clr) begin
         s_nxt.chan_seen = 6'h00;
         s_nxt.rise_f = 1'b0;
         s_nxt.fall_f = 1'b0;
         s_nxt.over_f = 1'b0;
         s_nxt.under_f = 1'b0;
         s_nxt.sv_f = 1'b0;
         s_nxt.ctl_f = 1'b0;
         s_nxt.oth_f = 1'b0;
      end

      s_nxt.chan_seen = s_nxt.chan_seen | seq_fault_chan_evt;
      s_nxt.rise_f = s_nxt.rise_f | rise_fault;
      s_nxt.fall_f = s_nxt.fall_f | fall_fault;
      s_nxt.over_f = s_nxt.over_f | over_trip;
      s_nxt.under_f = s_nxt.under_f | under_trip;
      s_nxt.sv_f = s_nxt.sv_f | sv_evt;
      s_nxt.ctl_f = s_nxt.ctl_f | seq_ctl_fault;
      s_nxt.oth_f = s_nxt.oth_f | ext_fault | sync_fault;

      // Own sequencing phase
      if (summ_clr && !seq_up_start) begin
         s_nxt.own_ph = ph_down_done;
         s_nxt.own_up = 1'b0;
      end

      if (seq_up_start) begin
         s_nxt.own_ph = ph_up_run;
         s_nxt.own_up = 1'b1;
      end else if (seq_up_done) begin
         s_nxt.own_ph = ph_up_done;
      end else if (seq_down_start) begin
         s_nxt.own_ph = ph_down_run;
         s_nxt.own_up = 1'b0;
      end else if (seq_down_done) begin
         s_nxt.own_ph = ph_down_done;
      end

      // Alert pull-down: release on read, a new fault wins
      if (fault_evt) begin
         s_nxt.alert = 1'b1;
      end else if (alert_rel) begin
         s_nxt.alert = 1'b0;
      end

      // First-fault copy
      if (first_fault) begin
         s_nxt.capture_req = 1'b1;
         s_nxt.cap_word = hist_word;
         s_nxt.armed = 1'b0;
      end

      if (take) begin
         if (cmd_rd) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_data = rd_word;
         end else begin
            s_nxt.clr_last = 1'b0;
            unique case (cmd_code)
               `NVCS_CMD_STORE: begin
                  if (store_ok) begin
                     s_nxt.store_req = 1'b1;
                     s_nxt.erase_req = s_r.clr_last;
                  end
               end
               `NVCS_CMD_RESTORE: begin
                  s_nxt.restore_req = 1'b1;
               end
               `NVCS_CMD_CLEAR: begin
                  s_nxt.clr_pulse = 1'b1;
                  s_nxt.clr_last = 1'b1;
                  s_nxt.armed = 1'b1;
               end
               `NVCS_CMD_LOCK: begin
                  if (key_match) begin
                     s_nxt.key_ok = 1'b1;
                     s_nxt.lock = cmd_wdata[`NVCS_LOCK_BIT];
                  end else begin
                     s_nxt.key_ok = 1'b0;
                  end
               end
               default: begin
                  s_nxt.clr_last = 1'b0;
               end
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.armed <= 1'b1;
         s_r.por_pend <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign nv_bus.store_req = s_r.store_req;
   assign nv_bus.erase_req = s_r.erase_req;
   assign nv_bus.restore_req = s_r.restore_req;
   assign nv_bus.capture_req = s_r.capture_req;
   assign nv_bus.capture_word = s_r.cap_word;
   assign nv_bus.work_data = cfg_work;

   // Outputs
   assign rd_valid = s_r.rd_valid;
   assign rd_data = s_r.rd_data;
   assign alert_out_n = 1'b0;
   assign alert_oe = s_r.alert;
   assign cfg_load_valid = nv_bus.load_valid;
   assign cfg_load_data = nv_bus.load_data;
   assign clear_pulse = s_r.clr_pulse;
   assign nvm_busy = nv_bus.busy;
endmodule : nvcs_top
`default_nettype wire

// file: src/nvcs_defines.svh
`ifndef NVCS_DEFINES_SVH
`define NVCS_DEFINES_SVH
`define NVCS_CMD_ALERT_REL 8'h28
`define NVCS_CMD_SUMMARY 8'h29
`define NVCS_CMD_STORE 8'h2c
`define NVCS_CMD_RESTORE 8'h2d
`define NVCS_CMD_CLEAR 8'h2e
`define NVCS_CMD_LOCK 8'h10
`define NVCS_LOCK_BIT 0
`define NVCS_KEY_LSB 2
`define NVCS_KEY_MSB 15
`define NVCS_PH_DOWN_DONE 2'h0
`define NVCS_PH_UP_RUN 2'h1
`define NVCS_PH_UP_DONE 2'h3
`define NVCS_PH_DOWN_RUN 2'h2
`define NVCS_CHAN_NONE 3'h0
`define NVCS_ZERO16 16'h0000
`define NVCS_CLK_MHZ 50
`define NVCS_STEP_TMO_NS 400
`define NVCS_STEP_TMO_CYC ((`NVCS_STEP_TMO_NS * `NVCS_CLK_MHZ + 999) / 1000)
`define NVCS_SYNC_LOW_NS 2000
`define NVCS_SYNC_LOW_CYC ((`NVCS_SYNC_LOW_NS * `NVCS_CLK_MHZ + 999) / 1000)
`define NVCS_NV_WR_CYC 4
`endif

// file: src/nvcs_pkg.sv
package nvcs_pkg;
   typedef enum logic [1:0] {ph_down_done, ph_up_run, ph_up_done, ph_down_run} nvcs_phase_t;
   typedef enum logic [2:0] {nv_idle, nv_store, nv_restore, nv_capture} nvcs_nvst_t;
   typedef struct packed {
      nvcs_phase_t own_ph;
      logic own_up;
      logic [5:0] chan_seen;
      logic rise_f;
      logic fall_f;
      logic over_f;
      logic under_f;
      logic sv_f;
      logic ctl_f;
      logic oth_f;
      logic dis;
      logic alert;
      logic lock;
      logic key_ok;
      logic clr_last;
      logic armed;
      logic por_pend;
      logic [15:0] rd_data;
      logic rd_valid;
      logic clr_pulse;
      logic [7:0] step_tmo;
      logic [7:0] sync_low;
      logic step_d;
      logic store_req;
      logic erase_req;
      logic restore_req;
      logic capture_req;
      logic [15:0] cap_word;
   } nvcs_top_t;
endpackage : nvcs_pkg

// file: src/nvcs_if.sv
`timescale 1ns/10ps
`default_nettype none
interface nvcs_if #(parameter int CFG_WORDS = 4);
   logic store_req;
   logic erase_req;
   logic restore_req;
   logic capture_req;
   logic [15:0] capture_word;
   logic [CFG_WORDS*16-1:0] work_data;
   logic busy;
   logic copy_valid;
   logic load_valid;
   logic [CFG_WORDS*16-1:0] load_data;
   modport ctl (output store_req, erase_req, restore_req, capture_req, capture_word, work_data,
                input busy, copy_valid, load_valid, load_data);
   modport mem (input store_req, erase_req, restore_req, capture_req, capture_word, work_data,
                output busy, copy_valid, load_valid, load_data);
endinterface : nvcs_if
`default_nettype wire

// file: src/nvcs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module nvcs_sync #(parameter int W = 3) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } nvcs_sync_t;
   nvcs_sync_t s_r;
   nvcs_sync_t s_nxt;

   always_comb begin
      s_nxt.s1 = d;
      s_nxt.s2 = s_r.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign q = s_r.s2;
endmodule : nvcs_sync
`default_nettype wire

// file: src/nvcs_nvm.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvcs_defines.svh"
module nvcs_nvm import nvcs_pkg::*; #(
   parameter int CFG_WORDS = 4,
   parameter int WR_CYC = `NVCS_NV_WR_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic nvm_erase_n,
   nvcs_if.mem bus
);
   localparam int IW = (CFG_WORDS > 1) ? $clog2(CFG_WORDS) : 1;
   typedef struct packed {
      nvcs_nvst_t st;
      logic [7:0] cnt;
      logic [7:0] idx;
      logic erase;
      logic cap_pend;
      logic [15:0] cap_word;
      logic load_valid;
      logic [CFG_WORDS*16-1:0] load_data;
   } nvcs_nvm_t;
   nvcs_nvm_t s_r;
   nvcs_nvm_t s_nxt;
   logic [CFG_WORDS-1:0][15:0] nv_mem_r;
   logic [15:0] nv_copy_r;
   logic nv_copy_valid_r;
   logic wr_cfg;
   logic wr_copy;
   logic clr_copy;
   logic done;

   assign done = (s_r.cnt == 8'(WR_CYC - 1));

   always_comb begin
      s_nxt = s_r;
      wr_cfg = 1'b0;
      wr_copy = 1'b0;
      clr_copy = 1'b0;
      s_nxt.load_valid = 1'b0;
      if (bus.capture_req) begin
         s_nxt.cap_pend = 1'b1;
         s_nxt.cap_word = bus.capture_word;
      end
      unique case (s_r.st)
         nv_idle: begin
            s_nxt.cnt = 8'h00;
            s_nxt.idx = 8'h00;
            if (bus.restore_req) begin
               s_nxt.st = nv_restore;
            end else if (bus.store_req) begin
               s_nxt.st = nv_store;
               s_nxt.erase = bus.erase_req;
            end else if (s_r.cap_pend) begin
               s_nxt.st = nv_capture;
            end
         end
         nv_store: begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (done) begin
               wr_cfg = 1'b1;
               s_nxt.cnt = 8'h00;
               s_nxt.idx = s_r.idx + 8'h01;
               if (s_r.idx == 8'(CFG_WORDS - 1)) begin
                  clr_copy = s_r.erase;
                  s_nxt.erase = 1'b0;
                  s_nxt.st = nv_idle;
               end
            end
         end
         nv_restore: begin
            s_nxt.load_data = nv_mem_r;
            s_nxt.load_valid = 1'b1;
            s_nxt.st = nv_idle;
         end
         nv_capture: begin
            s_nxt.cnt = s_r.cnt + 8'h01;
            if (done) begin
               wr_copy = 1'b1;
               s_nxt.cap_pend = bus.capture_req;
               s_nxt.st = nv_idle;
            end
         end
         default: s_nxt.st = nv_idle;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge clk or negedge nvm_erase_n) begin
      if (!nvm_erase_n) begin
         nv_mem_r <= '0;
         nv_copy_r <= `NVCS_ZERO16;
         nv_copy_valid_r <= 1'b0;
      end else begin
         if (wr_cfg) begin
            nv_mem_r[s_r.idx[IW-1:0]] <= bus.work_data[s_r.idx*16 +: 16];
         end
         if (wr_copy) begin
            nv_copy_r <= s_r.cap_word;
            nv_copy_valid_r <= 1'b1;
         end else if (clr_copy) begin
            nv_copy_r <= `NVCS_ZERO16;
            nv_copy_valid_r <= 1'b0;
         end
      end
   end

   assign bus.busy = (s_r.st != nv_idle) || bus.store_req || bus.restore_req;
   assign bus.copy_valid = nv_copy_valid_r;
   assign bus.load_valid = s_r.load_valid;
   assign bus.load_data = s_r.load_data;
endmodule : nvcs_nvm
`default_nettype wire

// file: test/nvcs_properties.sv
`timescale 1ns/10ps
`default_nettype none
module nvcs_properties (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_rd,
   input wire logic cmd_ready,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   input wire logic alert_oe,
   input wire logic [5:0] seq_fault_chan_evt,
   input wire logic rise_fault,
   input wire logic fall_fault,
   input wire logic over_trip,
   input wire logic under_trip,
   input wire logic supervise_trip,
   input wire logic seq_ctl_fault,
   input wire logic ext_fault,
   input wire logic all_discharged,
   input wire logic cfg_load_valid,
   input wire logic clear_pulse,
   input wire logic nvm_busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic any_evt;
   assign any_evt = (|seq_fault_chan_evt) | rise_fault | fall_fault | over_trip | under_trip
                    | supervise_trip | seq_ctl_fault | ext_fault;
   sequence s_rd;
      cmd_valid && cmd_ready && cmd_rd;
   endsequence
   sequence s_wr(c);
      cmd_valid && cmd_ready && !cmd_rd && cmd_code == c;
   endsequence
   rd_answer_a: assert property (s_rd |=> rd_valid)
      else $error("read taken without answer");
   rd_only_a: assert property (rd_valid |-> $past(cmd_valid && cmd_ready && cmd_rd))
      else $error("answer without read");
   alert_release_a: assert property ((s_rd ##0 (cmd_code == 8'h28 && !any_evt)) |=> !alert_oe)
      else $error("alert kept after release read");
   alert_set_a: assert property (any_evt |=> alert_oe)
      else $error("fault did not pull alert");
   clear_pulse_a: assert property (s_wr(8'h2e) |=> clear_pulse)
      else $error("clear gave no pulse");
   clear_only_a: assert property (clear_pulse
      |-> $past(cmd_valid && cmd_ready && !cmd_rd && cmd_code == 8'h2e))
      else $error("clear pulse without command");
   restore_load_a: assert property (s_wr(8'h2d) |-> ##3 cfg_load_valid)
      else $error("restore gave no load");
   busy_block_a: assert property (nvm_busy |-> !cmd_ready)
      else $error("ready while busy");
   por_load_a: assert property ($rose(rst_n) |-> ##[1:6] cfg_load_valid)
      else $error("no reload after reset");
   discharge_a: assert property ((s_rd ##0 (cmd_code == 8'h29 && $stable(all_discharged)))
      |=> rd_data[2] == $past(all_discharged))
      else $error("discharge bit wrong");
   busy_bound_a: assert property ($rose(nvm_busy) |-> ##[1:100] !nvm_busy)
      else $error("store never ends");
endmodule : nvcs_properties
bind nvcs_top nvcs_properties u_prop (.clk, .rst_n, .cmd_valid, .cmd_code, .cmd_rd, .cmd_ready,
   .rd_valid, .rd_data, .alert_oe, .seq_fault_chan_evt, .rise_fault, .fall_fault, .over_trip,
   .under_trip, .supervise_trip, .seq_ctl_fault, .ext_fault, .all_discharged, .cfg_load_valid,
   .clear_pulse, .nvm_busy);
`default_nettype wire

// file: test/nvcs_host.sv
`timescale 1ns/10ps
`default_nettype none
module nvcs_host (
   input wire logic clk,
   input wire logic cmd_ready,
   input wire logic rd_valid,
   input wire logic [15:0] rd_data,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic cmd_rd,
   output logic [15:0] cmd_wdata
);
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_rd = 1'b0;
      cmd_wdata = 16'h0000;
   end
   // Holds the command until taken; released code and data lines show inverted values, cmd_rd keeps its value
   task automatic xfer(input logic [7:0] c, input logic r, input logic [15:0] w,
                       output logic [15:0] d, output logic ok);
      int n;
      ok = 1'b1;
      d = 16'h0000;
      n = 0;
      @(posedge clk);
      #1;
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_rd = r;
      cmd_wdata = w;
      do begin
         @(posedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 200);
      if (n >= 200) ok = 1'b0;
      #1;
      cmd_valid = 1'b0;
      cmd_code = ~c;
      cmd_wdata = ~w;
      if (r) begin
         if (rd_valid !== 1'b1) ok = 1'b0;
         d = rd_data;
      end
   endtask : xfer
endmodule : nvcs_host
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "nvcs_defines.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   localparam logic [13:0] KEY = 14'h1a5c;
   localparam logic [12:0] ROW_EV [11] = '{13'h0080, 13'h1400, 13'h1000, 13'h0900, 13'h0040,
      13'h0020, 13'h0010, 13'h0008, 13'h0004, 13'h0002, 13'h0001};
   localparam logic [15:0] ROW_EXP [11] = '{16'h2000, 16'h8000, 16'hc000, 16'h4000, 16'h0080,
      16'h0040, 16'h0028, 16'h0018, 16'h0008, 16'h0002, 16'h0001};
   localparam logic [5:0] PHX = 6'b001011;
   logic clk, rst_n, nvm_erase_n, wp_pin, step_clock_line, shared_sync_line, alert_in_n;
   logic cmd_valid, cmd_rd, cmd_ready, rd_valid, alert_out_n, alert_oe, all_discharged;
   logic cfg_load_valid, clear_pulse, nvm_busy, step_run, seen;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rd_data, hist_word, rdat;
   logic [63:0] cfg_work, cfg_load_data;
   logic [16:0] ev;
   wire logic seq_up_start, seq_up_done, seq_down_start, seq_down_done, rise_fault, fall_fault;
   wire logic over_trip, under_trip, supervise_trip, seq_ctl_fault, ext_fault;
   wire logic [5:0] seq_fault_chan_evt;
   int bad_count = 0;
   int cmp_count = 0;
   assign {seq_up_start, seq_up_done, seq_down_start, seq_down_done, seq_fault_chan_evt,
      rise_fault, fall_fault, over_trip, under_trip, supervise_trip, seq_ctl_fault,
      ext_fault} = ev;
   nvcs_top #(.SEC_KEY(KEY)) DUT (.clk, .rst_n, .nvm_erase_n, .cmd_valid, .cmd_code, .cmd_rd,
      .cmd_wdata, .cmd_ready, .rd_valid, .rd_data, .wp_pin, .step_clock_line,
      .shared_sync_line, .alert_in_n, .alert_out_n, .alert_oe, .seq_up_start, .seq_up_done,
      .seq_down_start, .seq_down_done, .seq_fault_chan_evt, .rise_fault, .fall_fault,
      .over_trip, .under_trip, .supervise_trip, .seq_ctl_fault, .ext_fault, .all_discharged,
      .hist_word, .cfg_work, .cfg_load_valid, .cfg_load_data, .clear_pulse, .nvm_busy);
   nvcs_host HOST (.clk, .cmd_ready, .rd_valid, .rd_data, .cmd_valid, .cmd_code, .cmd_rd,
      .cmd_wdata);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #7;
      forever #80 if (step_run) step_clock_line = ~step_clock_line;
   end
   task automatic stop_test();
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic cmd(input logic [7:0] c, input logic r, input logic [15:0] w);
      logic ok;
      HOST.xfer(c, r, w, rdat, ok);
      `CHK(ok, 1'b1)
      if (ok !== 1'b1) stop_test();
   endtask : cmd
   task automatic pls(input logic [16:0] v);
      cyc(1);
      ev = v;
      cyc(1);
      ev = 17'h00000;
   endtask : pls
   task automatic wait_load();
      int n;
      n = 0;
      while (cfg_load_valid !== 1'b1 && n < 50) begin
         cyc(1);
         n++;
      end
      `CHK(n < 50, 1'b1)
      if (n >= 50) stop_test();
   endtask : wait_load
   // Reports whether the store started, then waits for it to end
   task automatic store_try(output logic s);
      int n;
      n = 0;
      cmd(`NVCS_CMD_STORE, 1'b0, 16'h0000);
      s = 1'b0;
      repeat (3) begin
         cyc(1);
         s = s | nvm_busy;
      end
      while (nvm_busy !== 1'b0 && n < 100) begin
         cyc(1);
         n++;
      end
      `CHK(n < 100, 1'b1)
   endtask : store_try
   task automatic rd_sum();
      cmd(`NVCS_CMD_SUMMARY, 1'b1, 16'h0000);
   endtask : rd_sum
   initial begin
      {rst_n, nvm_erase_n, wp_pin, step_clock_line, step_run, alert_in_n} = 6'b000001;
      {shared_sync_line, all_discharged, ev} = {2'b10, 17'h00000};
      hist_word = 16'h5a3c;
      cfg_work = 64'h1111_2222_3333_4444;
      cyc(2);
      nvm_erase_n = 1'b1;
      cyc(2);
      rst_n = 1'b1;
      wait_load();
      `CHK(cfg_load_data, 64'h0)
      rd_sum();
      `CHK(rdat, 16'h0000)
      for (int i = 0; i < 11; i++) begin
         cmd(`NVCS_CMD_CLEAR, 1'b0, 16'h0000);
         `CHK(clear_pulse, 1'b1)
         pls({4'h0, ROW_EV[i]});
         rd_sum();
         `CHK(rdat & 16'he0fb, ROW_EXP[i])
         `CHK(alert_oe, 1'b1)
         `CHK(alert_out_n, 1'b0)
         cmd(`NVCS_CMD_ALERT_REL, 1'b1, 16'h0000);
         `CHK(alert_oe, 1'b0)
         rd_sum();
         `CHK(rdat & 16'he0fb, ROW_EXP[i])
         $display("Row %0d done", i);
      end
      `CHK(rdat[12], 1'b1)
      cmd(`NVCS_CMD_LOCK, 1'b0, {KEY, 2'b00});
      store_try(seen);
      `CHK(seen, 1'b1)
      cfg_work = 64'hdead_beef_0bad_f00d;
      wp_pin = 1'b1;
      cyc(3);
      store_try(seen);
      `CHK(seen, 1'b0)
      wp_pin = 1'b0;
      cmd(`NVCS_CMD_LOCK, 1'b0, {KEY, 2'b01});
      cmd(`NVCS_CMD_LOCK, 1'b1, 16'h0000);
      `CHK(rdat[0], 1'b1)
      store_try(seen);
      `CHK(seen, 1'b0)
      cmd(`NVCS_CMD_LOCK, 1'b0, {KEY, 2'b00});
      cmd(`NVCS_CMD_LOCK, 1'b0, {~KEY, 2'b00});
      store_try(seen);
      `CHK(seen, 1'b0)
      cmd(`NVCS_CMD_RESTORE, 1'b0, 16'h0000);
      wait_load();
      `CHK(cfg_load_data, 64'h1111_2222_3333_4444)
      $display("Protection test done");
      cmd(`NVCS_CMD_LOCK, 1'b0, {KEY, 2'b00});
      cmd(`NVCS_CMD_CLEAR, 1'b0, 16'h0000);
      rd_sum();
      `CHK(rdat[12], 1'b1)
      store_try(seen);
      rd_sum();
      `CHK(rdat[12], 1'b0)
      rst_n = 1'b0;
      cyc(4);
      rst_n = 1'b1;
      wait_load();
      `CHK(cfg_load_data, 64'hdead_beef_0bad_f00d)
      $display("Clear store reset test done");
      pls(17'h00040);
      pls(17'h10000);
      step_run = 1'b1;
      cyc(12);
      rd_sum();
      `CHK(rdat & 16'h0c80, 16'h0400)
      `CHK(rdat[9:8], 2'b01)
      step_run = 1'b0;
      for (int j = 0; j < 3; j++) begin
         pls({4'b0100 >> j, 13'h0000});
         rd_sum();
         `CHK(rdat[11:10], PHX[2*j+:2])
      end
      for (int k = 0; k < 2; k++) begin
         all_discharged = (k == 0);
         cyc(3);
         rd_sum();
         `CHK(rdat[2], all_discharged)
      end
      shared_sync_line = 1'b0;
      cyc(120);
      shared_sync_line = 1'b1;
      cyc(3);
      rd_sum();
      `CHK(rdat[0], 1'b1)
      cmd(`NVCS_CMD_CLEAR, 1'b0, 16'h0000);
      cmd(`NVCS_CMD_SUMMARY, 1'b0, 16'hffff);
      rd_sum();
      `CHK(rdat & 16'he0fb, 16'h0000)
      cmd(8'h7f, 1'b1, 16'h0000);
      `CHK(rdat, 16'h0000)
      $display("Phase and line test done");
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
